// >>> verilog/ssc_pkg.sv
// ssc_pkg: constants and types of the sync serial port core
package ssc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_DATA  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_PRESC = 8'h10;
  localparam logic [7:0] OFS_MASK  = 8'h14;
  localparam logic [7:0] OFS_RAW   = 8'h18;
  localparam logic [7:0] OFS_MSKD  = 8'h1C;
  localparam logic [7:0] OFS_ICLR  = 8'h20;
  // field positions
  localparam int ICLR_OVR_BIT = 0;
  localparam int ICLR_TMO_BIT = 1;
  // reset values
  localparam logic [15:0] CTRL0_RST = 16'h0000;
  localparam logic [1:0]  CTRL1_RST = 2'h0;
  localparam logic [7:0]  PRESC_RST = 8'h00;
  localparam logic [3:0]  MASK_RST  = 4'h0;
  // sizes and counts
  localparam int          FIFO_W      = 16;
  localparam int          FIFO_D      = 8;
  localparam logic [3:0]  FIFO_FULL   = 4'h8;
  localparam logic [3:0]  TX_IRQ_LVL  = 4'h4;
  localparam logic [3:0]  RX_IRQ_LVL  = 4'h4;
  localparam logic [5:0]  TMO_BITS    = 6'h20;
  localparam logic [4:0]  CW_BITS     = 5'h08;
  localparam logic [3:0]  SIZE_MIN_M1 = 4'h3;

  typedef enum logic [1:0] {
    FMT_FOUR  = 2'h0,
    FMT_PULSE = 2'h1,
    FMT_CTRL  = 2'h2
  } ssc_fmt_t;

  typedef struct packed {
    logic [7:0] rate;
    logic       pha;
    logic       pol;
    ssc_fmt_t   fmt;
    logic [3:0] size;
  } ssc_ctrl0_t;

  typedef struct packed {
    logic slave;
    logic enable;
  } ssc_ctrl1_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic tmo;
    logic ovr;
  } ssc_irq_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_GAP  = 3'b100
  } ssc_state_t;
endpackage

// >>> verilog/ssc_core.sv
// ssc_core: register-mapped synchronous serial port with fifos
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ssc_core (
  // system
  input  wire logic        clock,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // serial pins
  input  wire logic        serialClockIn,
  output logic             serialClockOut,
  output logic             serialClockOeN,
  input  wire logic        frameSelectIn,
  output logic             frameSelectOut,
  output logic             frameSelectOeN,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOeN,
  // interrupt
  output logic             combinedIrq
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  ssc_pkg::ssc_ctrl0_t ctrl0_q;
  ssc_pkg::ssc_ctrl1_t ctrl1_q;
  ssc_pkg::ssc_irq_t   mask_q;
  ssc_pkg::ssc_irq_t   raw;
  ssc_pkg::ssc_irq_t   masked;
  ssc_pkg::ssc_state_t state_q, state_d;
  logic [7:0]  presc_q;
  logic [6:0]  preCnt_q;
  logic [7:0]  rateCnt_q;
  logic        halfPar_q;
  logic [4:0]  slot_q, slot_d;
  logic        inB_q, inB_d;
  logic        arm_q, arm_d;
  logic [15:0] txSh_q, txSh_d;
  logic [15:0] rxSh_q, rxSh_d;
  logic [15:0] rxWord;
  logic        txPopE, rxDoneE, frameStart, mStart;
  logic        clkPrev_q;
  logic [5:0]  idleCnt_q;
  logic        tmo_q, ovr_q;
  logic [1:0]  fPush, fPop;
  logic [15:0] fDin [2];
  logic [15:0] fHead [2];
  logic [3:0]  fCnt [2];

  // bus decode
  wire logic wrEn   = write & ~waitrequest;
  wire logic rdEn   = read & ~waitrequest;
  wire logic clrOvr = wrEn & hit(address, ssc_pkg::OFS_ICLR)
                      & writedata[ssc_pkg::ICLR_OVR_BIT];
  wire logic clrTmo = wrEn & hit(address, ssc_pkg::OFS_ICLR)
                      & writedata[ssc_pkg::ICLR_TMO_BIT];

  // fifo levels
  wire logic [3:0] txCnt   = fCnt[0];
  wire logic [3:0] rxCnt   = fCnt[1];
  wire logic       txEmpty = txCnt == 4'h0;
  wire logic       rxFull  = rxCnt == ssc_pkg::FIFO_FULL;
  wire logic       rxPop   = rdEn & hit(address, ssc_pkg::OFS_DATA) & (rxCnt != 4'h0);
  // a read in the same cycle frees the slot for the finishing word
  wire logic       rxRoom  = ~rxFull | rxPop;

  // fifos: index 0 transmit, 1 receive
  assign fPush[0] = wrEn & hit(address, ssc_pkg::OFS_DATA) & (txCnt != ssc_pkg::FIFO_FULL);
  assign fDin[0]  = writedata[15:0];
  assign fPop[0]  = txPopE;
  assign fPush[1] = rxDoneE & rxRoom & ~ovr_q;
  assign fDin[1]  = rxWord;
  assign fPop[1]  = rxPop;

  for (genvar g = 0; g < 2; g++) begin : g_fifo
    logic [15:0] mem_q [ssc_pkg::FIFO_D];
    logic [2:0]  wp_q;
    logic [2:0]  rp_q;
    logic [3:0]  cnt_q;
    always_ff @(posedge clock) begin
      if (fPush[g]) begin
        mem_q[wp_q] <= fDin[g];
      end
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        wp_q  <= 3'h0;
        rp_q  <= 3'h0;
        cnt_q <= 4'h0;
      end else begin
        wp_q  <= wp_q + {2'h0, fPush[g]};
        rp_q  <= rp_q + {2'h0, fPop[g]};
        cnt_q <= cnt_q + {3'h0, fPush[g]} - {3'h0, fPop[g]};
      end
    end
    assign fHead[g] = mem_q[rp_q];
    assign fCnt[g]  = cnt_q;
  end

  // prescaler: lsb of divisor dropped, so only even ratios
  wire logic [6:0] halfDiv  = (presc_q[7:1] == 7'h00) ? 7'h01 : presc_q[7:1];
  wire logic       preWrap  = preCnt_q == halfDiv - 7'h01;
  wire logic       rateWrap = rateCnt_q == ctrl0_q.rate;
  wire logic       halfTick = preWrap & rateWrap;
  wire logic       bitTick  = halfTick & halfPar_q;

  // frame geometry
  wire logic isPulse = ctrl0_q.fmt == ssc_pkg::FMT_PULSE;
  wire logic isCtrl  = ctrl0_q.fmt == ssc_pkg::FMT_CTRL;
  wire logic isFour  = ~isPulse & ~isCtrl;
  wire logic [4:0] nBits = (ctrl0_q.size < ssc_pkg::SIZE_MIN_M1) ? 5'h04
                           : {1'b0, ctrl0_q.size} + 5'h01;
  wire logic [4:0] rxFirst  = isPulse ? 5'h01 : isCtrl ? ssc_pkg::CW_BITS + 5'h01 : 5'h00;
  wire logic [4:0] txFirst  = isPulse ? 5'h01 : 5'h00;
  wire logic [4:0] txLast   = isCtrl ? ssc_pkg::CW_BITS - 5'h01
                              : isPulse ? nBits : nBits - 5'h01;
  wire logic [4:0] lastSlot = rxFirst + nBits - 5'h01;
  wire logic [4:0] txAlign  = isCtrl ? ssc_pkg::CW_BITS : 5'h10 - nBits;
  // msb first: word is left-aligned in the shifter
  wire logic [15:0] loadWord = txEmpty ? 16'h0000 : fHead[0] << txAlign;
  wire logic [15:0] rxMask   = 16'hFFFF >> (5'h10 - nBits);
  wire logic [15:0] rxIn     = {rxSh_q[14:0], serialDataIn};

  // slave edge detection, pins taken as synchronous
  wire logic rise     = serialClockIn & ~clkPrev_q;
  wire logic fall     = ~serialClockIn & clkPrev_q;
  wire logic lead     = ctrl0_q.pol ? fall : rise;
  wire logic trail    = ctrl0_q.pol ? rise : fall;
  wire logic shiftEv  = isPulse ? rise : ctrl0_q.pha ? lead : trail;
  wire logic sampleEv = isPulse ? fall : ctrl0_q.pha ? trail : lead;
  wire logic slvStart = isPulse ? (fall & frameSelectIn) : ~frameSelectIn;
  wire logic run      = state_q == ssc_pkg::ST_RUN;
  wire logic txReady  = ~txEmpty & ~ctrl1_q.slave;

  always_comb begin
    state_d    = state_q;
    slot_d     = slot_q;
    inB_d      = inB_q;
    arm_d      = arm_q;
    txSh_d     = txSh_q;
    rxSh_d     = rxSh_q;
    rxWord     = rxSh_q & rxMask;
    txPopE     = 1'b0;
    rxDoneE    = 1'b0;
    frameStart = 1'b0;
    mStart     = 1'b0;
    if (!ctrl1_q.enable) begin
      state_d = ssc_pkg::ST_IDLE;
      slot_d  = 5'h00;
      inB_d   = 1'b0;
    end else if (ctrl1_q.slave) begin
      case (state_q)
        ssc_pkg::ST_IDLE: begin
          if (slvStart) begin
            state_d    = ssc_pkg::ST_RUN;
            slot_d     = 5'h00;
            txSh_d     = loadWord;
            txPopE     = ~txEmpty;
            arm_d      = isFour & ~ctrl0_q.pha;
            frameStart = 1'b1;
          end
        end
        ssc_pkg::ST_RUN: begin
          if (isFour & frameSelectIn) begin
            state_d = ssc_pkg::ST_IDLE;
          end else begin
            if (shiftEv) begin
              if (arm_q) begin
                txSh_d = txSh_q << 1;
              end
              arm_d = 1'b1;
            end
            if (sampleEv) begin
              rxSh_d = rxIn;
              slot_d = slot_q + 5'h01;
              if (slot_q == nBits - 5'h01) begin
                rxWord  = rxIn & rxMask;
                rxDoneE = 1'b1;
                slot_d  = 5'h00;
                txSh_d  = loadWord;
                txPopE  = ~txEmpty;
                arm_d   = isFour & ~ctrl0_q.pha;
                if (isPulse) begin
                  state_d = ssc_pkg::ST_IDLE;
                end
              end
            end
          end
        end
        default: state_d = ssc_pkg::ST_IDLE;
      endcase
    end else begin
      case (state_q)
        ssc_pkg::ST_IDLE: mStart = halfTick & txReady;
        ssc_pkg::ST_RUN: begin
          if (halfTick) begin
            inB_d = ~inB_q;
            if (!inB_q) begin
              if (slot_q >= rxFirst) begin
                rxSh_d = rxIn;
              end
            end else if (slot_q == lastSlot) begin
              rxDoneE = 1'b1;
              state_d = isPulse ? ssc_pkg::ST_IDLE : ssc_pkg::ST_GAP;
              mStart  = isPulse & txReady;  // back to back pulse frames
            end else begin
              slot_d = slot_q + 5'h01;
              if (slot_q >= txFirst && slot_q < txLast) begin
                txSh_d = txSh_q << 1;
              end
            end
          end
        end
        ssc_pkg::ST_GAP: begin
          // one bit of deselect between frames
          if (halfTick) begin
            inB_d = ~inB_q;
            if (inB_q) begin
              state_d = ssc_pkg::ST_IDLE;
            end
          end
        end
        default: state_d = ssc_pkg::ST_IDLE;
      endcase
      if (mStart) begin
        state_d    = ssc_pkg::ST_RUN;
        slot_d     = 5'h00;
        inB_d      = 1'b0;
        txSh_d     = loadWord;
        txPopE     = 1'b1;
        frameStart = 1'b1;
      end
    end
  end

  // pin values
  wire logic sckIdle = isFour & ctrl0_q.pol;
  wire logic sckRun  = isFour ? ctrl0_q.pol ^ (ctrl0_q.pha ? ~inB_q : inB_q)
                       : isPulse ? ~inB_q : inB_q;
  wire logic sckD    = run ? sckRun : sckIdle;
  wire logic selD    = isPulse ? (run & slot_q == 5'h00) : ~run;
  wire logic doD     = run & ~(isCtrl & slot_q >= ssc_pkg::CW_BITS) & txSh_q[15];
  wire logic doOeND  = ctrl1_q.slave ? ~run
                       : isPulse ? ~(run & slot_q != 5'h00) : ~ctrl1_q.enable;

  // timeout and overrun
  wire logic idleOk = ~run & (rxCnt != 4'h0) & ~rxPop;
  wire logic tmoSet = idleOk & bitTick & (idleCnt_q == ssc_pkg::TMO_BITS - 6'h01);
  wire logic ovrSet = (rxDoneE & ~rxRoom) | (frameStart & rxFull);
  wire logic tmoClr = clrTmo | (frameStart & ~rxFull);

  assign raw = '{tx:  (txCnt <= ssc_pkg::TX_IRQ_LVL) | ~ctrl1_q.enable,
                 rx:  rxCnt >= ssc_pkg::RX_IRQ_LVL,
                 tmo: tmo_q,
                 ovr: ovr_q};
  assign masked = raw & mask_q;

  wire logic [4:0] status = {run, rxFull, rxCnt != 4'h0, txCnt != ssc_pkg::FIFO_FULL, txEmpty};
  wire logic [31:0] rdMux =
      hit(address, ssc_pkg::OFS_CTRL0) ? {16'h0000, ctrl0_q}
    : hit(address, ssc_pkg::OFS_CTRL1) ? {29'h0000_0000, ctrl1_q, 1'b0}
    : hit(address, ssc_pkg::OFS_DATA)  ? {16'h0000, fHead[1] & {16{rxCnt != 4'h0}}}
    : hit(address, ssc_pkg::OFS_STAT)  ? {27'h0000_000, status}
    : hit(address, ssc_pkg::OFS_PRESC) ? {24'h0000_00, presc_q}
    : hit(address, ssc_pkg::OFS_MASK)  ? {28'h0000_000, mask_q}
    : hit(address, ssc_pkg::OFS_RAW)   ? {28'h0000_000, raw}
    : hit(address, ssc_pkg::OFS_MSKD)  ? {28'h0000_000, masked}
    : 32'h0000_0000;

  // bus slave: one wait cycle, then the access completes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        readdata <= rdMux;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl0_q <= ssc_pkg::CTRL0_RST;
      ctrl1_q <= ssc_pkg::CTRL1_RST;
      presc_q <= ssc_pkg::PRESC_RST;
      mask_q  <= ssc_pkg::MASK_RST;
    end else if (wrEn) begin
      if (hit(address, ssc_pkg::OFS_CTRL0)) ctrl0_q <= writedata[15:0];
      if (hit(address, ssc_pkg::OFS_CTRL1)) ctrl1_q <= writedata[2:1];
      if (hit(address, ssc_pkg::OFS_PRESC)) presc_q <= writedata[7:0];
      if (hit(address, ssc_pkg::OFS_MASK))  mask_q  <= writedata[3:0];
    end
  end

  // free-running two-stage prescaler
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      preCnt_q  <= 7'h00;
      rateCnt_q <= 8'h00;
      halfPar_q <= 1'b0;
    end else begin
      preCnt_q  <= preWrap ? 7'h00 : preCnt_q + 7'h01;
      rateCnt_q <= !preWrap ? rateCnt_q : rateWrap ? 8'h00 : rateCnt_q + 8'h01;
      halfPar_q <= halfPar_q ^ halfTick;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q   <= ssc_pkg::ST_IDLE;
      slot_q    <= 5'h00;
      inB_q     <= 1'b0;
      arm_q     <= 1'b0;
      txSh_q    <= 16'h0000;
      rxSh_q    <= 16'h0000;
      clkPrev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      slot_q    <= slot_d;
      inB_q     <= inB_d;
      arm_q     <= arm_d;
      txSh_q    <= txSh_d;
      rxSh_q    <= rxSh_d;
      clkPrev_q <= serialClockIn;
    end
  end

  // set wins over clear on both flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idleCnt_q <= 6'h00;
      tmo_q     <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      idleCnt_q <= !idleOk ? 6'h00
                   : (bitTick && idleCnt_q != ssc_pkg::TMO_BITS) ? idleCnt_q + 6'h01
                   : idleCnt_q;
      tmo_q     <= tmoSet | (tmo_q & ~tmoClr);
      ovr_q     <= ovrSet | (ovr_q & ~clrOvr);
    end
  end

  // registered pins; slave leaves clock and select undriven
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serialClockOut <= 1'b0;
      serialClockOeN <= 1'b0;
      frameSelectOut <= 1'b1;
      frameSelectOeN <= 1'b0;
      serialDataOut  <= 1'b0;
      serialDataOeN  <= 1'b1;
      combinedIrq    <= 1'b0;
    end else begin
      serialClockOut <= sckD;
      serialClockOeN <= ctrl1_q.slave;
      frameSelectOut <= selD;
      frameSelectOeN <= ctrl1_q.slave;
      serialDataOut  <= doD;
      serialDataOeN  <= doOeND;
      combinedIrq    <= |masked;
    end
  end
endmodule
`default_nettype wire

// >>> bench/ssc_core_monitor.sv
// ssc_core_monitor: concurrent pin and register checks for the port core
`timescale 1ns/10ps
`default_nettype none
module ssc_core_monitor (
  // system
  input wire logic        clock,
  input wire logic        nrst,
  // avalon-mm
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // serial pins
  input wire logic        serialClockOut,
  input wire logic        frameSelectOut,
  input wire logic        serialDataOeN
);
  ssc_pkg::ssc_ctrl0_t ctrl0_q;
  ssc_pkg::ssc_ctrl1_t ctrl1_q;
  logic [7:0]          presc_q;
  logic [3:0]          mask_q;
  logic [2:0]          quiet_q;
  logic [16:0]         selHi_q;
  logic [16:0]         clkHi_q;
  wire                 takenW = write && !waitrequest;
  wire                 cfgW   = takenW && (address == ssc_pkg::OFS_CTRL0
                                || address == ssc_pkg::OFS_CTRL1 || address == ssc_pkg::OFS_PRESC);
  wire  [7:0]          divW   = (presc_q[7:1] == 7'h00) ? 8'h02 : {presc_q[7:1], 1'b0};
  wire  [16:0]         bitW   = 17'(divW) * 17'({1'b0, ctrl0_q.rate} + 9'h001);
  // pins lag a config write, so checks wait until it has settled
  wire                 idleW  = quiet_q == 3'h7 && !ctrl1_q.slave;
  wire                 fourW  = idleW && ctrl0_q.fmt == ssc_pkg::FMT_FOUR;
  wire                 pulseW = idleW && ctrl0_q.fmt == ssc_pkg::FMT_PULSE;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl0_q <= ssc_pkg::CTRL0_RST;
      ctrl1_q <= ssc_pkg::CTRL1_RST;
      presc_q <= ssc_pkg::PRESC_RST;
      mask_q  <= ssc_pkg::MASK_RST;
      quiet_q <= 3'h0;
      selHi_q <= 17'h0;
      clkHi_q <= 17'h0;
    end else begin
      if (takenW && address == ssc_pkg::OFS_CTRL0) ctrl0_q <= writedata[15:0];
      if (takenW && address == ssc_pkg::OFS_CTRL1) ctrl1_q <= writedata[2:1];
      if (takenW && address == ssc_pkg::OFS_PRESC) presc_q <= writedata[7:0];
      if (takenW && address == ssc_pkg::OFS_MASK) mask_q <= writedata[3:0];
      quiet_q <= cfgW ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
      selHi_q <= frameSelectOut ? selHi_q + 17'h1 : 17'h0;
      clkHi_q <= serialClockOut ? clkHi_q + 17'h1 : 17'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  tx_off_a: assert property (
    !waitrequest && read && address == ssc_pkg::OFS_RAW && !ctrl1_q.enable |-> readdata[3])
    else $error("transmit flag low while port disabled");
  masked_sub_a: assert property (
    !waitrequest && read && address == ssc_pkg::OFS_MSKD |-> (readdata[3:0] & ~mask_q) == 4'h0)
    else $error("masked status shows a disabled source");
  idle_clock_a: assert property (
    idleW && !ctrl1_q.enable |-> serialClockOut == (fourW && ctrl0_q.pol))
    else $error("idle serial clock at wrong level");
  frame_select_a: assert property (
    fourW && $rose(serialClockOut) |-> !frameSelectOut)
    else $error("serial clock edge outside a selected frame");
  pulse_idle_a: assert property (
    pulseW && !ctrl1_q.enable |-> serialDataOeN && !serialClockOut && !frameSelectOut)
    else $error("pulse format idle pins wrong");
  pulse_width_a: assert property (
    pulseW && $fell(frameSelectOut) |-> selHi_q == bitW)
    else $error("frame pulse not one bit long");
  half_bit_a: assert property (
    fourW && ctrl1_q.enable && !ctrl0_q.pol && $fell(serialClockOut) |-> {clkHi_q, 1'b0} == bitW)
    else $error("serial clock high time off");
  start_frame_a: assert property (
    fourW && ctrl1_q.enable && takenW && address == ssc_pkg::OFS_DATA |-> ##[1:600] !frameSelectOut)
    else $error("no frame after data write");
endmodule
bind ssc_core ssc_core_monitor ssc_core_monitor_i (
  .clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .serialClockOut(serialClockOut), .frameSelectOut(frameSelectOut),
  .serialDataOeN(serialDataOeN));
`default_nettype wire

// >>> bench/ssc_peer.sv
// ssc_peer: far-side shift register peripheral that echoes the last word
`timescale 1ns/10ps
`default_nettype none
module ssc_peer #(
  parameter logic [15:0] INIT = 16'hC35A
) (
  // serial pins
  input  wire logic       sck,
  input  wire logic       sel,
  input  wire logic       mosi,
  output logic            miso,
  // frame size minus one
  input  wire logic [3:0] size
);
  logic [15:0] shift_q = INIT;
  logic        bit_q   = 1'b0;
  logic        act_q   = 1'b0;
  // sample on rise, advance on fall, only while selected
  // select is taken at the rise: at the last fall it moves in the same step
  always @(posedge sck) begin
    if (!sel) bit_q <= mosi;
    act_q <= !sel;
  end
  always @(negedge sck) begin
    if (act_q) shift_q <= {shift_q[14:0], bit_q};
  end
  // released line shows the inverse, never a held value
  assign miso = sel ? ~shift_q[size] : shift_q[size];
endmodule
`default_nettype wire

// >>> bench/ssc_core_bench.sv
// ssc_core_bench: random and corner tests of the serial port core
`timescale 1ns/10ps
`default_nettype none
module ssc_core_bench;
  localparam logic [15:0] PEER_INIT = 16'hC35A;
  logic        clock, nrst, read, write, lastDo, miso, mosi;
  logic        waitrequest, sclk, scOeN, fsel, fsOeN, sdo, sdoOeN, combinedIrq;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  size;
  logic [15:0] hist;
  logic        sck, sfs, sdi, slv;
  logic [7:0]  so, rxB;
  wire logic   sdIn = slv ? sdi : miso;
  logic [15:0] expQ [$];
  logic [7:0]  prT [3] = '{8'h03, 8'h07, 8'h00};
  logic [7:0]  rtT [3] = '{8'h01, 8'h01, 8'h02};
  logic [3:0]  szT [3] = '{4'h3, 4'hF, 4'h7};
  int          fail_count, checked;
  ssc_core ssc_core_i (.clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .serialClockIn(sck), .serialClockOut(sclk), .serialClockOeN(scOeN),
    .frameSelectIn(sfs), .frameSelectOut(fsel), .frameSelectOeN(fsOeN),
    .serialDataIn(sdIn), .serialDataOut(sdo), .serialDataOeN(sdoOeN),
    .combinedIrq(combinedIrq));
  ssc_peer #(.INIT(PEER_INIT)) ssc_peer_i (.sck(sclk), .sel(fsel), .mosi(mosi),
    .miso(miso), .size(size));
  // a released data line must not look like a held bit
  assign mosi = sdoOeN ? ~lastDo : sdo;
  always @(posedge clock) if (!sdoOeN) lastDo <= sdo;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [15:0] fmask(input logic [3:0] s);
    return 16'hFFFF >> (5'h0F - {1'b0, s});
  endfunction
  task automatic end_sim;
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) fail_count++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic push(input logic [15:0] w);
    bus(1'b1, ssc_pkg::OFS_DATA, {16'h0000, w});
    expQ.push_back(hist & fmask(size));
    hist = (hist << ({1'b0, size} + 5'h01)) | (w & fmask(size));
  endtask
  task automatic pop;
    bus(1'b0, ssc_pkg::OFS_DATA, 32'h0);
    chk(q, {16'h0000, expQ.pop_front()});
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, ssc_pkg::OFS_STAT, 32'h0);
      n++;
    end while ((q[4] !== 1'b0 || q[0] !== 1'b1) && n < 3000);
    if (n == 3000) fail_count++;
  endtask
  task automatic cfg(input logic [7:0] pr, input logic [7:0] r, input ssc_pkg::ssc_fmt_t f,
                     input logic [3:0] s, input logic en);
    bus(1'b1, ssc_pkg::OFS_CTRL1, 32'h0);
    bus(1'b1, ssc_pkg::OFS_PRESC, {24'h00_0000, pr});
    bus(1'b1, ssc_pkg::OFS_CTRL0, {16'h0000, r, 2'b00, f, s});
    size = s;
    repeat (10) @(posedge clock);
    bus(1'b1, ssc_pkg::OFS_CTRL1, {30'h0, en, 1'b0});
  endtask
  initial begin
    repeat (80000) @(posedge clock);
    fail_count++;
    end_sim;
  end
  initial begin
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
    lastDo = 1'b0; size = 4'hF; hist = PEER_INIT; fail_count = 0; checked = 0;
    sck = 1'b0; sfs = 1'b1; sdi = 1'b0; slv = 1'b0; so = 8'h00;
    q = $urandom(14749);
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdc(ssc_pkg::OFS_CTRL0, 32'hFFFF, {16'h0000, ssc_pkg::CTRL0_RST});
    rdc(ssc_pkg::OFS_MASK, 32'hF, {28'h0, ssc_pkg::MASK_RST});
    rdc(ssc_pkg::OFS_RAW, 32'hF, 32'h8);
    rdc(8'h24, 32'hFFFF_FFFF, 32'h0);
    rdc(ssc_pkg::OFS_DATA, 32'hFFFF_FFFF, 32'h0);
    // odd divisor 21 behaves as 20; seven words keep the count above four
    cfg(8'h15, 8'h00, ssc_pkg::FMT_FOUR, 4'hF, 1'b0);
    repeat (7) push(16'($urandom));
    rdc(ssc_pkg::OFS_RAW, 32'h8, 32'h8);
    bus(1'b1, ssc_pkg::OFS_CTRL1, 32'h2);
    rdc(ssc_pkg::OFS_RAW, 32'h8, 32'h0);
    idle;
    rdc(ssc_pkg::OFS_RAW, 32'hF, 32'hC);
    repeat (4) pop;
    rdc(ssc_pkg::OFS_RAW, 32'h4, 32'h0);
    repeat (700) @(posedge clock);
    rdc(ssc_pkg::OFS_RAW, 32'h2, 32'h2);
    bus(1'b1, ssc_pkg::OFS_ICLR, 32'h0);
    rdc(ssc_pkg::OFS_RAW, 32'h2, 32'h2);
    push(16'($urandom));
    idle;
    rdc(ssc_pkg::OFS_RAW, 32'h2, 32'h0);
    repeat (4) pop;
    for (int i = 0; i < 3; i++) begin
      cfg(prT[i], rtT[i], ssc_pkg::FMT_FOUR, szT[i], 1'b1);
      repeat (2) push(16'($urandom));
      idle;
      repeat (2) pop;
    end
    repeat (8) push(16'($urandom));
    idle;
    rdc(ssc_pkg::OFS_STAT, 32'h8, 32'h8);
    rdc(ssc_pkg::OFS_RAW, 32'h1, 32'h0);
    push(16'hA55A);
    idle;
    rdc(ssc_pkg::OFS_RAW, 32'h1, 32'h1);
    bus(1'b1, ssc_pkg::OFS_ICLR, 32'h1);
    rdc(ssc_pkg::OFS_RAW, 32'h1, 32'h0);
    repeat (8) pop;
    void'(expQ.pop_front());
    rdc(ssc_pkg::OFS_DATA, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, ssc_pkg::OFS_ICLR, 32'h3);
    rdc(ssc_pkg::OFS_RAW, 32'hF, 32'h8);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, ssc_pkg::OFS_MASK, i);
      rdc(ssc_pkg::OFS_MSKD, 32'hF, 32'(8 & i));
      chk({31'h0, combinedIrq}, {31'h0, i[3]});
    end
    cfg(8'h03, 8'h01, ssc_pkg::FMT_PULSE, 4'h7, 1'b1);
    repeat (2) push(16'($urandom));
    idle;
    rdc(ssc_pkg::OFS_STAT, 32'h4, 32'h4);
    // slave four-wire: preload, then a far master clocks one byte in and out
    cfg(8'h00, 8'h00, ssc_pkg::FMT_FOUR, 4'h7, 1'b0);
    repeat (2) bus(1'b0, ssc_pkg::OFS_DATA, 32'h0);
    bus(1'b1, ssc_pkg::OFS_DATA, 32'h0000_00B4);
    bus(1'b1, ssc_pkg::OFS_CTRL1, 32'h6);
    rxB = 8'($urandom);
    slv <= 1'b1;
    sfs <= 1'b0;
    // 24 clocks per bit keeps the far clock well under a twelfth
    for (int i = 7; i >= 0; i--) begin
      sdi <= rxB[i];
      repeat (12) @(posedge clock);
      sck <= 1'b1;
      so = {so[6:0], sdo};
      repeat (12) @(posedge clock);
      sck <= 1'b0;
    end
    repeat (12) @(posedge clock);
    sfs <= 1'b1;
    repeat (4) @(posedge clock);
    chk({24'h0, so}, 32'h0000_00B4);
    rdc(ssc_pkg::OFS_DATA, 32'hFFFF, {24'h0, rxB});
    end_sim;
  end
endmodule
`default_nettype wire
